// *** rtl/drb_pkg.sv ***
// Package: constants and carrier types for the data retention backup control block
package drb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DELAY     = 8'h04;
  localparam logic [7:0] REG_TARGET    = 8'h08;
  localparam logic [7:0] REG_SERIAL    = 8'h0C;
  localparam logic [7:0] REG_GAPS      = 8'h10;
  localparam logic [7:0] REG_GEOM      = 8'h14;
  localparam logic [7:0] REG_PREAMBLE  = 8'h18;
  localparam logic [7:0] REG_STATUS    = 8'h1C;
  localparam logic [7:0] REG_COMMAND   = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_AUTO_SAVE    = 0;
  localparam int CTRL_AUTO_RESTORE = 1;
  localparam int CTRL_VERIFY       = 2;
  localparam int CTRL_LINKED       = 3;
  localparam int CTRL_WP_LOW_BATT  = 4;
  localparam int CTRL_SPIN_SAVE    = 5;
  localparam int CMD_REFORMAT      = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]  CTRL_RESET         = 6'h23;
  localparam logic [7:0]  SAVE_DELAY_RESET   = 8'h05;
  localparam logic [7:0]  SAVE_DELAY_MIN     = 8'h01;
  localparam logic [2:0]  TARGET_ID_RESET    = 3'h1;
  localparam logic [15:0] SERIAL_RESET       = 16'h0000;
  localparam logic [7:0]  HEADER_GAP_RESET   = 8'h11;
  localparam logic [7:0]  DATA_GAP_RESET     = 8'h11;
  localparam logic [7:0]  TAIL_GAP_RESET     = 8'h20;
  localparam logic [7:0]  SPARE_RESET        = 8'h00;
  localparam logic [7:0]  SECTORS_RESET      = 8'h04;
  localparam logic [7:0]  TRACKS_RESET       = 8'h80;
  localparam logic [7:0]  COPIES_RESET       = 8'h01;
  localparam logic [7:0]  DATA_PRE_RESET     = 8'h0F;
  localparam logic [7:0]  HDR_PRE_RESET      = 8'h0C;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ           = 200000000;
  localparam longint TICK_CYCLES      = CLK_HZ;
  localparam int     BITS_PER_WORD    = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VOL_NO_DATA = 2'h0,
    VOL_VALID   = 2'h1,
    VOL_INVALID = 2'h2
  } drb_vol_t;

  typedef struct packed {
    logic       auto_save;
    logic       auto_restore;
    logic       verify;
    logic       linked;
    logic       wp_low_batt;
    logic       spin_save;
    logic [7:0] save_delay;
    logic [2:0] target_id;
  } drb_cfg_t;

  typedef struct packed {
    logic [7:0] header_lead_gap;
    logic [7:0] data_lead_gap;
    logic [7:0] sector_tail_gap;
    logic [7:0] spare_blocks_per_track;
    logic [7:0] sectors_per_track;
    logic [7:0] tracks_per_cylinder;
    logic [7:0] table_copies;
    logic [7:0] data_preamble;
    logic [7:0] header_preamble;
  } drb_geom_t;

  typedef struct packed {
    logic       start;
    logic       linked;
    logic       verify;
    logic [2:0] target_id;
  } drb_disk_cmd_t;

endpackage : drb_pkg

// *** rtl/drb_tick_gen.sv ***
// Seconds tick divider
`timescale 1ns/1ps
module drb_tick_gen
  import drb_pkg::*;
#(
  parameter longint PERIOD = TICK_CYCLES
)(
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  logic [31:0] count;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      count    <= 32'h0;
      tick_out <= 1'b0;
    end
    else if (count == 32'(PERIOD - 1))
    begin
      count    <= 32'h0;
      tick_out <= 1'b1;
    end
    else
    begin
      count    <= count + 32'h1;
      tick_out <= 1'b0;
    end
  end

  a_tick_single : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    tick_out |=> !tick_out)
    else $error("tick longer than one cycle");

endmodule : drb_tick_gen

// *** rtl/drb_sync2.sv ***
// Two-flop synchroniser
`timescale 1ns/1ps
module drb_sync2 #(
  parameter int WIDTH = 1
)(
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : drb_sync2

// *** rtl/drb_ctrl.sv ***
// Data retention backup control: options, geometry and save/restore sequencing
//
// Operation
// - Auto save on AC fail when battery ready
// - Auto save off: AC fail goes to shutdown
// - Auto restore at power-up if volume valid
// - No restore: initialise array, then format
// - Save delay 1 to 255 seconds
// - Backup disk target ID, default 1
// - Verify before save done; default off
// - Linked commands only when option set
// - Write protect until battery ready option
// - Unprotected writes while battery not ready mark volume invalid
// - Spin-down starts save when enabled
// - Four-digit serial reported as drive identifier
// - Format from restore or generated
// - Header lead gap in words, default 17
// - Data lead gap in words, default 17
// - Sector tail gap in words, default 32
// - Spare blocks per track, default 0
// - Sectors per track, default 4
// - Tracks per cylinder, default 128
// - Table copies, default 1
// - Data preamble reported, default 15
// - Header preamble reported, default 12
// - Volume status valid, invalid or none
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module drb_ctrl
  import drb_pkg::*;
#(
  parameter longint TICK_PERIOD = TICK_CYCLES
)(
  input  wire logic      ref_clk_in,
  input  wire logic      rst_n_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Power and battery monitor pins
  input  wire logic        ac_fail_in,
  input  wire logic        batt_ready_in,
  // Host events, controller domain
  input  wire logic        spin_down_in,
  input  wire logic        host_wr_req_in,
  input  wire logic        saved_vol_valid_in,
  // Backup disk path
  output drb_disk_cmd_t    save_cmd_out,
  output drb_disk_cmd_t    restore_cmd_out,
  input  wire logic        disk_done_in,
  input  wire logic        verify_done_in,
  // Storage array
  output logic             array_init_out,
  output logic             array_format_out,
  input  wire logic        array_done_in,
  output drb_geom_t        geom_out,
  output logic             write_protect_out,
  output logic             host_wr_ok_out,
  output logic [15:0]      drive_id_out,
  output drb_vol_t         vol_status_out,
  output logic             shutdown_out
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_BOOT     = 10'h001,
    ST_RESTORE  = 10'h002,
    ST_INIT     = 10'h004,
    ST_FORMAT   = 10'h008,
    ST_ONLINE   = 10'h010,
    ST_DELAY    = 10'h020,
    ST_SAVE     = 10'h040,
    ST_VERIFY   = 10'h080,
    ST_SHUTDOWN = 10'h100,
    ST_SPIN     = 10'h200
  } drb_state_t;

  drb_state_t  state;
  drb_cfg_t    cfg;
  drb_geom_t   geom;
  logic [15:0] serial;
  logic [7:0]  delay_left;
  logic        tick;
  logic [1:0]  pins_sync;
  logic        ac_fail;
  logic        batt_ready;
  logic        reformat_req;

  // ----------------------------------------------------------------
  // Pin synchronisers and seconds tick
  // ----------------------------------------------------------------
  drb_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({ac_fail_in, batt_ready_in}),
    .sync_out   (pins_sync)
  );

  assign ac_fail    = pins_sync[1];
  assign batt_ready = pins_sync[0];

  drb_tick_gen #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .tick_out   (tick)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      {cfg.spin_save, cfg.wp_low_batt, cfg.linked, cfg.verify, cfg.auto_restore,
       cfg.auto_save} <= CTRL_RESET;
      cfg.save_delay <= SAVE_DELAY_RESET;
      cfg.target_id  <= TARGET_ID_RESET;
      serial         <= SERIAL_RESET;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        REG_CTRL:
        begin
          cfg.auto_save    <= reg_wdata_in[CTRL_AUTO_SAVE];
          cfg.auto_restore <= reg_wdata_in[CTRL_AUTO_RESTORE];
          cfg.verify       <= reg_wdata_in[CTRL_VERIFY];
          cfg.linked       <= reg_wdata_in[CTRL_LINKED];
          cfg.wp_low_batt  <= reg_wdata_in[CTRL_WP_LOW_BATT];
          cfg.spin_save    <= reg_wdata_in[CTRL_SPIN_SAVE];
        end
        REG_DELAY:
          // Zero held at the floor
          cfg.save_delay <= (reg_wdata_in[7:0] < SAVE_DELAY_MIN) ?
                            SAVE_DELAY_MIN : reg_wdata_in[7:0];
        REG_TARGET:
          cfg.target_id <= reg_wdata_in[2:0];
        REG_SERIAL:
          // Four BCD digits, 0000 to 9999
          serial <= reg_wdata_in[15:0];
        default:
          ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Format geometry registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      geom.header_lead_gap        <= HEADER_GAP_RESET;
      geom.data_lead_gap          <= DATA_GAP_RESET;
      geom.sector_tail_gap        <= TAIL_GAP_RESET;
      geom.spare_blocks_per_track <= SPARE_RESET;
      geom.sectors_per_track      <= SECTORS_RESET;
      geom.tracks_per_cylinder    <= TRACKS_RESET;
      geom.table_copies           <= COPIES_RESET;
      geom.data_preamble          <= DATA_PRE_RESET;
      geom.header_preamble        <= HDR_PRE_RESET;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        REG_GAPS:
        begin
          geom.header_lead_gap <= reg_wdata_in[7:0];
          geom.data_lead_gap   <= reg_wdata_in[15:8];
          geom.sector_tail_gap <= reg_wdata_in[23:16];
        end
        REG_GEOM:
        begin
          geom.spare_blocks_per_track <= reg_wdata_in[7:0];
          geom.sectors_per_track      <= reg_wdata_in[15:8];
          geom.tracks_per_cylinder    <= reg_wdata_in[23:16];
          geom.table_copies           <= reg_wdata_in[31:24];
        end
        REG_PREAMBLE:
        begin
          geom.data_preamble   <= reg_wdata_in[7:0];
          geom.header_preamble <= reg_wdata_in[15:8];
        end
        default:
          ;
      endcase
    end
  end

  assign reformat_req = reg_wr_in && (reg_addr_in == REG_COMMAND) &&
                        reg_wdata_in[CMD_REFORMAT];

  // ----------------------------------------------------------------
  // Save / restore sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state      <= ST_BOOT;
      delay_left <= 8'h00;
    end
    else
    begin
      case (state)
        ST_BOOT:
          if (cfg.auto_restore && saved_vol_valid_in)
            state <= ST_RESTORE;
          else
            state <= ST_INIT;
        ST_RESTORE:
          if (disk_done_in)
            state <= ST_ONLINE;
        ST_INIT:
          if (array_done_in)
            state <= ST_FORMAT;
        ST_FORMAT:
          if (array_done_in)
            state <= ST_ONLINE;
        ST_ONLINE:
          if (ac_fail)
          begin
            if (cfg.auto_save && batt_ready)
            begin
              state      <= ST_DELAY;
              delay_left <= cfg.save_delay;
            end
            else
              state <= ST_SHUTDOWN;
          end
          else if (spin_down_in && cfg.spin_save)
            state <= ST_SAVE;
          else if (reformat_req)
            state <= ST_INIT;
        ST_DELAY:
          if (tick)
          begin
            if (delay_left == 8'h01)
              state <= ST_SAVE;
            delay_left <= delay_left - 8'h01;
          end
        ST_SAVE:
          if (disk_done_in)
            state <= cfg.verify ? ST_VERIFY :
                     (ac_fail ? ST_SHUTDOWN : ST_SPIN);
        ST_VERIFY:
          if (verify_done_in)
            state <= ac_fail ? ST_SHUTDOWN : ST_SPIN;
        ST_SHUTDOWN:
          state <= ST_SHUTDOWN;
        ST_SPIN:
          if (!spin_down_in)
            state <= ST_ONLINE;
        default:
          state <= ST_BOOT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Volume status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      vol_status_out <= VOL_NO_DATA;
    else if (state == ST_BOOT)
      vol_status_out <= saved_vol_valid_in ? VOL_VALID : VOL_NO_DATA;
    else if (host_wr_req_in && !write_protect_out && !batt_ready)
      vol_status_out <= VOL_INVALID;
    else if ((state == ST_SAVE && disk_done_in && !cfg.verify) ||
             (state == ST_VERIFY && verify_done_in))
      vol_status_out <= VOL_VALID;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      save_cmd_out      <= '0;
      restore_cmd_out   <= '0;
      array_init_out    <= 1'b0;
      array_format_out  <= 1'b0;
      write_protect_out <= 1'b0;
      host_wr_ok_out    <= 1'b0;
      shutdown_out      <= 1'b0;
      geom_out          <= '0;
      drive_id_out      <= 16'h0000;
    end
    else
    begin
      save_cmd_out.start     <= (state == ST_SAVE) || (state == ST_VERIFY);
      save_cmd_out.linked    <= cfg.linked;
      save_cmd_out.verify    <= cfg.verify;
      save_cmd_out.target_id <= cfg.target_id;
      restore_cmd_out.start     <= (state == ST_RESTORE);
      restore_cmd_out.linked    <= cfg.linked;
      restore_cmd_out.verify    <= 1'b0;
      restore_cmd_out.target_id <= cfg.target_id;
      array_init_out    <= (state == ST_INIT);
      array_format_out  <= (state == ST_FORMAT);
      // Protect stays until the battery can carry a save
      write_protect_out <= cfg.wp_low_batt && !batt_ready;
      host_wr_ok_out    <= host_wr_req_in && (state == ST_ONLINE) &&
                           !(cfg.wp_low_batt && !batt_ready);
      shutdown_out      <= (state == ST_SHUTDOWN);
      geom_out          <= geom;
      drive_id_out      <= serial;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 32'h0;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        REG_CTRL:     reg_rdata_out <= {26'h0, cfg.spin_save, cfg.wp_low_batt, cfg.linked,
                                        cfg.verify, cfg.auto_restore, cfg.auto_save};
        REG_DELAY:    reg_rdata_out <= {24'h0, cfg.save_delay};
        REG_TARGET:   reg_rdata_out <= {29'h0, cfg.target_id};
        REG_SERIAL:   reg_rdata_out <= {16'h0, serial};
        REG_GAPS:     reg_rdata_out <= {8'h0, geom.sector_tail_gap, geom.data_lead_gap,
                                        geom.header_lead_gap};
        REG_GEOM:     reg_rdata_out <= {geom.table_copies, geom.tracks_per_cylinder,
                                        geom.sectors_per_track, geom.spare_blocks_per_track};
        REG_PREAMBLE: reg_rdata_out <= {16'h0, geom.header_preamble, geom.data_preamble};
        REG_STATUS:   reg_rdata_out <= {20'h0, state, vol_status_out};
        default:      reg_rdata_out <= 32'h0;
      endcase
    end
    else
      reg_rdata_out <= 32'h0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_save_on_fail : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == ST_ONLINE && ac_fail && cfg.auto_save && batt_ready) |=> state == ST_DELAY)
    else $error("auto save not started");
  a_no_save_off : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == ST_ONLINE && ac_fail && !cfg.auto_save) |=> state == ST_SHUTDOWN)
    else $error("shutdown not taken");
  a_restore_pick : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == ST_BOOT && cfg.auto_restore && saved_vol_valid_in) |=> state == ST_RESTORE)
    else $error("restore skipped");
  a_init_format : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == ST_INIT && array_done_in) |=> state == ST_FORMAT)
    else $error("format not after init");
  a_delay_floor : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cfg.save_delay != 8'h00)
    else $error("save delay zero");
  a_verify_path : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == ST_SAVE && disk_done_in && cfg.verify) |=> state == ST_VERIFY)
    else $error("verify skipped");
  a_wp_low_batt : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (cfg.wp_low_batt && !batt_ready) |=> !host_wr_ok_out)
    else $error("write accepted while protected");
  a_spin_save : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == ST_ONLINE && !ac_fail && spin_down_in && !cfg.spin_save) |=> state != ST_SAVE)
    else $error("save on spin down while disabled");
  a_id_report : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ##1 drive_id_out == $past(serial))
    else $error("drive id mismatch");

  c_auto_save   : cover property (@(posedge ref_clk_in) state == ST_DELAY ##[1:1000] state == ST_SAVE);
  c_restore     : cover property (@(posedge ref_clk_in) state == ST_RESTORE);
  c_shutdown    : cover property (@(posedge ref_clk_in) state == ST_SHUTDOWN);
  c_invalidate  : cover property (@(posedge ref_clk_in) vol_status_out == VOL_INVALID);

endmodule : drb_ctrl

// *** test/drb_backup_model.sv ***
// Backup disk and storage array partner
`timescale 1ns/1ps
module drb_backup_model
  import drb_pkg::*;
#(
  parameter int LAT = 6
)(
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  input  wire drb_disk_cmd_t save_cmd_in,
  input  wire drb_disk_cmd_t restore_cmd_in,
  input  wire logic          array_init_in,
  input  wire logic          array_format_in,
  output logic               disk_done_out,
  output logic               verify_done_out,
  output logic               array_done_out
);
  int   disk_cnt;
  int   arr_cnt;
  logic verify_phase;

  // ----------------------------------------------------------------
  // Backup disk
  // ----------------------------------------------------------------
  // LAT above output lag, else one request is answered twice
  always_ff @(posedge ref_clk_in)
  begin
    disk_done_out   <= 1'b0;
    verify_done_out <= 1'b0;
    if (!rst_n_in || !(save_cmd_in.start || restore_cmd_in.start))
    begin
      disk_cnt     <= 0;
      verify_phase <= 1'b0;
    end
    else if (disk_cnt == LAT)
    begin
      disk_cnt        <= 0;
      disk_done_out   <= !verify_phase;
      verify_done_out <= verify_phase;
      verify_phase    <= save_cmd_in.start && save_cmd_in.verify;
    end
    else
      disk_cnt <= disk_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    array_done_out <= 1'b0;
    if (!rst_n_in || !(array_init_in || array_format_in))
      arr_cnt <= 0;
    else if (arr_cnt == LAT)
    begin
      arr_cnt        <= 0;
      array_done_out <= 1'b1;
    end
    else
      arr_cnt <= arr_cnt + 1;
  end
endmodule : drb_backup_model

// *** test/tb_top.sv ***
// Bench for the retention sequencer
`timescale 1ns/1ps
module tb_top;
  import drb_pkg::*;
  localparam longint TP = 10;
  logic          ref_clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  logic [7:0]    reg_addr_in = 8'h00;
  logic [31:0]   reg_wdata_in = 32'h0, reg_rdata_out, rdata;
  logic          reg_wr_in = 1'b0, reg_rd_in = 1'b0, ac_fail_in = 1'b0, batt_ready_in = 1'b0;
  logic          spin_down_in = 1'b0, host_wr_req_in = 1'b0, saved_vol_valid_in = 1'b0;
  logic          disk_done_in, verify_done_in, array_done_in, array_init_out, array_format_out;
  logic          write_protect_out, host_wr_ok_out, shutdown_out, saw_save;
  logic [15:0]   drive_id_out;
  drb_disk_cmd_t save_cmd_out, restore_cmd_out;
  drb_geom_t     geom_out;
  drb_vol_t      vol_status_out;
  int            fail_count = 0, checks = 0, n;

  drb_ctrl #(.TICK_PERIOD(TP)) drb_ctrl_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ac_fail_in(ac_fail_in),
    .batt_ready_in(batt_ready_in), .spin_down_in(spin_down_in), .host_wr_req_in(host_wr_req_in),
    .saved_vol_valid_in(saved_vol_valid_in), .save_cmd_out(save_cmd_out),
    .restore_cmd_out(restore_cmd_out), .disk_done_in(disk_done_in),
    .verify_done_in(verify_done_in), .array_init_out(array_init_out),
    .array_format_out(array_format_out), .array_done_in(array_done_in), .geom_out(geom_out),
    .write_protect_out(write_protect_out), .host_wr_ok_out(host_wr_ok_out),
    .drive_id_out(drive_id_out), .vol_status_out(vol_status_out), .shutdown_out(shutdown_out));
  drb_backup_model drb_backup_model_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .save_cmd_in(save_cmd_out), .restore_cmd_in(restore_cmd_out),
    .array_init_in(array_init_out), .array_format_in(array_format_out),
    .disk_done_out(disk_done_in), .verify_done_out(verify_done_in),
    .array_done_out(array_done_in));

  always #2.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
    if (save_cmd_out.start === 1'b1)
      saw_save <= 1'b1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk_in);
  endtask : cyc
  // A hang ends the run
  task automatic step;
    @(posedge ref_clk_in);
    n++;
    if (n > 400)
    begin
      $display("BAD timeout expected 400 seen %0d", n);
      fail_count++;
      give_verdict();
    end
  endtask : step
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    rdata = reg_rdata_out;
  endtask : rd
  function automatic logic sel(int k);
    case (k)
      0: return save_cmd_out.start;
      1: return restore_cmd_out.start;
      2: return array_init_out;
      3: return array_format_out;
      default: return shutdown_out;
    endcase
  endfunction : sel
  task automatic wait_for(int k);
    n = 0;
    while (sel(k) !== 1'b1)
      step();
  endtask : wait_for
  task automatic go_online;
    cyc(4);
    n = 0;
    while ((sel(1) | sel(2) | sel(3)) !== 1'b0)
      step();
  endtask : go_online
  task automatic do_reset;
    rst_n_in <= 1'b0;
    cyc(8);
    rst_n_in <= 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_boot;
    wait_for(2);
    chk("format_in_init", array_format_out, 0);
    wait_for(3);
    chk("init_in_format", array_init_out, 0);
    chk("restore_no_volume", restore_cmd_out.start, 0);
    go_online();
    wr(REG_COMMAND, 32'h1);
    wait_for(3);
    go_online();
    $display("boot done");
  endtask : t_boot
  task automatic t_regs;
    rd(REG_CTRL);
    chk("ctrl", rdata, 32'h00000023);
    rd(REG_TARGET);
    chk("target", rdata, 32'h00000001);
    rd(REG_GAPS);
    chk("gaps", rdata, 32'h00201111);
    rd(REG_GEOM);
    chk("geom", rdata, 32'h01800400);
    rd(REG_PREAMBLE);
    chk("preamble", rdata, 32'h00000C0F);
    chk("geom_tail", geom_out.sector_tail_gap, 32'h20);
    rd(8'h24);
    chk("unmapped", rdata, 32'h0);
    wr(REG_DELAY, 32'h0);
    rd(REG_DELAY);
    chk("delay_floor", rdata, 32'h00000001);
    wr(REG_SERIAL, 32'h00004096);
    cyc(2);
    chk("drive_id", drive_id_out, 32'h4096);
    $display("regs done");
  endtask : t_regs
  task automatic t_protect;
    host_wr_req_in <= 1'b1;
    cyc(4);
    chk("wr_ok_unprot", host_wr_ok_out, 1);
    host_wr_req_in <= 1'b0;
    cyc(2);
    chk("vol_invalid", vol_status_out, VOL_INVALID);
    wr(REG_CTRL, 32'h00000033);
    host_wr_req_in <= 1'b1;
    cyc(4);
    chk("wp_on", write_protect_out, 1);
    chk("wr_ok_prot", host_wr_ok_out, 0);
    host_wr_req_in <= 1'b0;
    batt_ready_in  <= 1'b1;
    cyc(5);
    chk("wp_released", write_protect_out, 0);
    $display("protect done");
  endtask : t_protect
  task automatic t_spin;
    wr(REG_CTRL, 32'h0000002F);
    wr(REG_TARGET, 32'h00000005);
    spin_down_in <= 1'b1;
    wait_for(0);
    chk("save_linked", save_cmd_out.linked, 1);
    chk("save_target", save_cmd_out.target_id, 5);
    cyc(9);
    chk("verify_pending", save_cmd_out.start, 1);
    cyc(16);
    chk("vol_valid", vol_status_out, VOL_VALID);
    spin_down_in <= 1'b0;
    wr(REG_CTRL, 32'h0000000F);
    saw_save     <= 1'b0;
    spin_down_in <= 1'b1;
    cyc(20);
    chk("spin_no_save", saw_save, 0);
    spin_down_in <= 1'b0;
    $display("spin done");
  endtask : t_spin
  task automatic t_ac_save;
    do_reset();
    go_online();
    wr(REG_DELAY, 32'h00000002);
    ac_fail_in <= 1'b1;
    wait_for(0);
    chk("save_delay", (n >= TP) && (n <= 2 * TP + 8), 1);
    chk("save_unlinked", save_cmd_out.linked, 0);
    wait_for(4);
    chk("vol_after_save", vol_status_out, VOL_VALID);
    ac_fail_in <= 1'b0;
    $display("auto save done");
  endtask : t_ac_save
  // Pass 0: auto save off; pass 1: battery not ready
  task automatic t_no_save;
    for (int i = 0; i < 2; i++)
    begin
      do_reset();
      go_online();
      if (i == 0)
        wr(REG_CTRL, 32'h00000022);
      batt_ready_in <= (i == 0);
      saw_save      <= 1'b0;
      cyc(4);
      ac_fail_in <= 1'b1;
      wait_for(4);
      chk("shutdown_no_save", saw_save, 0);
      ac_fail_in    <= 1'b0;
      batt_ready_in <= 1'b1;
    end
    $display("no save done");
  endtask : t_no_save
  task automatic t_restore;
    saved_vol_valid_in <= 1'b1;
    do_reset();
    wait_for(1);
    chk("init_on_restore", array_init_out, 0);
    chk("restore_target", restore_cmd_out.target_id, 1);
    go_online();
    chk("format_after_restore", array_format_out, 0);
    saved_vol_valid_in <= 1'b0;
    $display("restore done");
  endtask : t_restore

  initial
  begin
    cyc(8);
    rst_n_in <= 1'b1;
    t_boot();
    t_regs();
    t_protect();
    t_spin();
    t_ac_save();
    t_no_save();
    t_restore();
    give_verdict();
  end
endmodule : tb_top
